// *** rtl/fan_alert_pkg.sv ***
/*
 * constants shared by the fan fault status and alert block:
 * register offsets, field positions, reset values and write masks.
 * assumes an 8-bit register port driven by an smbus protocol engine
 * that presents one decoded byte access per request.
 */
package fan_alert_pkg;

    // number of fan channels covered by the status registers
    localparam int FAN_COUNT = 5;

    // register offsets on the byte-wide register port
    localparam logic [7:0] ADDR_GLOBAL_CONFIGURATION = 8'h20;
    localparam logic [7:0] ADDR_FAULT_SUMMARY = 8'h24;
    localparam logic [7:0] ADDR_STALL_STATUS = 8'h25;
    localparam logic [7:0] ADDR_SPINUP_STATUS = 8'h26;
    localparam logic [7:0] ADDR_DRIVE_FAIL_STATUS = 8'h27;
    localparam logic [7:0] ADDR_ALERT_ENABLE = 8'h29;

    // global configuration field positions
    localparam int CFG_ALERT_MASK_BIT = 7;
    localparam int CFG_TIMEOUT_DISABLE_BIT = 6;
    localparam int CFG_WATCHDOG_CONT_BIT = 5;
    localparam int CFG_CLOCK_DRIVE_BIT = 1;
    localparam int CFG_EXT_CLOCK_USE_BIT = 0;

    // writable bits of the configuration; bits 4..2 stay zero
    localparam logic [7:0] CFG_WRITE_MASK = 8'he3;

    // fault summary field positions
    localparam int SUM_WATCHDOG_BIT = 7;
    localparam int SUM_DRIVE_FAIL_BIT = 2;
    localparam int SUM_SPINUP_BIT = 1;
    localparam int SUM_STALL_BIT = 0;

    // reset values
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [4:0] ALERT_ENABLE_RESET = 5'h00;
    localparam logic [4:0] FLAGS_RESET = 5'h00;
    localparam logic [7:0] READ_DATA_RESET = 8'h00;

    // answer to an unmapped read
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

    // default divide ratio of the internal tachometer time base
    localparam int INT_TACH_DIV_DEFAULT = 4;

endpackage

// *** rtl/fan_fault_status_alert.sv ***
/*
 * fault status, alert gating and global configuration of a
 * multi-channel fan controller.
 * assumes: an smbus protocol engine on mclk presents byte reads and
 * writes as one-cycle strobes; stall, spin-up and drive-fail detectors
 * and the watchdog counter run on mclk and supply level conditions and
 * an expiry pulse; the tachometer clock pin arrives as its own clock.
 */
`timescale 1ns/1ps

module fan_fault_status_alert
    import fan_alert_pkg::*;
#(
    parameter int NUM_FANS = FAN_COUNT,
    parameter int INT_TACH_DIV = INT_TACH_DIV_DEFAULT
) (
    input wire logic mclk,
    input wire logic rst_b,
    // register port from the smbus engine
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // software lock from the lock register
    input wire logic sw_lock,
    // per-fan detector conditions, levels on mclk
    input wire logic [NUM_FANS-1:0] stall_cond,
    input wire logic [NUM_FANS-1:0] spinup_fail_cond,
    input wire logic [NUM_FANS-1:0] drive_fail_cond,
    // watchdog expiry pulse and per-fan reprogram pulses
    input wire logic watchdog_expire,
    input wire logic [NUM_FANS-1:0] fan_reprogram,
    // watchdog control and forced full duty
    output logic watchdog_run,
    output logic [NUM_FANS-1:0] force_full_duty,
    // smbus timeout enable toward the protocol engine
    output logic bus_timeout_enable,
    // alert pin, active low, push-pull style level
    output logic alert_n,
    // tachometer clock pin: its clock, and drive toward it
    input wire logic tach_pin_clk,
    output logic tach_pin_out,
    output logic tach_pin_oe,
    // selected tachometer time base tick
    output logic tach_tick
);

    localparam int DIV_W = (INT_TACH_DIV > 1) ? $clog2(INT_TACH_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INT_TACH_DIV - 1);
    localparam logic [DIV_W-1:0] DIV_ZERO = '0;
    localparam logic [NUM_FANS-1:0] FAN_ZERO = '0;

    // configuration register, only writable bits are kept
    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    // per-fan alert enables
    logic [NUM_FANS-1:0] alert_en_q;
    // per-fan sticky status flags
    logic [NUM_FANS-1:0] stall_q;
    logic [NUM_FANS-1:0] stall_d;
    logic [NUM_FANS-1:0] spin_q;
    logic [NUM_FANS-1:0] spin_d;
    logic [NUM_FANS-1:0] drive_q;
    logic [NUM_FANS-1:0] drive_d;
    // watchdog expired flag
    logic watch_q;
    logic watch_d;
    // one-shot watchdog already spent
    logic wd_spent_q;
    // per-fan full duty force
    logic [NUM_FANS-1:0] force_q;
    // summary bits
    logic any_stall;
    logic any_spinup_fail;
    logic any_drive_fail;
    logic [7:0] summary;
    // read data and alert registers
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rvalid_q;
    logic alert_n_q;
    logic alert_req;
    // decoded configuration controls
    logic alert_mask;
    logic bus_timeout_disable;
    logic watchdog_continuous;
    logic tach_clock_drive_out;
    logic external_tach_clock_use;
    logic use_ext_clock;
    // access strobes
    logic rd_summary;
    logic rd_stall;
    logic rd_spin;
    logic rd_drive;
    // internal tachometer time base
    logic [DIV_W-1:0] div_q;
    logic int_tick;
    logic int_clk_q;
    // link-side toggle and its crossing
    logic link_tgl_q;
    logic link_sync1_q;
    logic link_sync2_q;
    logic link_sync3_q;
    logic ext_tick;

    // widen a fan vector into the low bits of a byte
    function automatic logic [7:0] to_byte(input logic [NUM_FANS-1:0] v);
        logic [7:0] b;
        b = 8'h00;
        b[NUM_FANS-1:0] = v;
        return b;
    endfunction

    // read-to-clear update: live condition always wins
    function automatic logic [NUM_FANS-1:0] rc_next(
        input logic [NUM_FANS-1:0] flags,
        input logic [NUM_FANS-1:0] cond,
        input logic rd
    );
        logic [NUM_FANS-1:0] n;
        n = cond | (rd ? FAN_ZERO : flags);
        return n;
    endfunction

    // configuration fields
    assign alert_mask = cfg_q[CFG_ALERT_MASK_BIT];
    assign bus_timeout_disable = cfg_q[CFG_TIMEOUT_DISABLE_BIT];
    assign watchdog_continuous = cfg_q[CFG_WATCHDOG_CONT_BIT];
    assign tach_clock_drive_out = cfg_q[CFG_CLOCK_DRIVE_BIT];
    assign external_tach_clock_use = cfg_q[CFG_EXT_CLOCK_USE_BIT];

    // timeout active unless software disables it
    assign bus_timeout_enable = ~bus_timeout_disable;

    // read strobes per status register
    assign rd_summary = reg_rd && (reg_addr == ADDR_FAULT_SUMMARY);
    assign rd_stall = reg_rd && (reg_addr == ADDR_STALL_STATUS);
    assign rd_spin = reg_rd && (reg_addr == ADDR_SPINUP_STATUS);
    assign rd_drive = reg_rd && (reg_addr == ADDR_DRIVE_FAIL_STATUS);

    // configuration write; lock freezes it, middle bits never stored
    always_comb begin
        cfg_d = cfg_q;
        if (reg_wr && (reg_addr == ADDR_GLOBAL_CONFIGURATION) && !sw_lock) begin
            cfg_d = reg_wdata & CFG_WRITE_MASK;
        end
    end

    // configuration register
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q <= CFG_RESET;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // alert enables; reset leaves every fan disabled
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            alert_en_q <= ALERT_ENABLE_RESET[NUM_FANS-1:0];
        end else if (reg_wr && (reg_addr == ADDR_ALERT_ENABLE)) begin
            alert_en_q <= reg_wdata[NUM_FANS-1:0];
        end
    end

    // per-fan flag next values
    always_comb begin
        stall_d = rc_next(stall_q, stall_cond, rd_stall);
        spin_d = rc_next(spin_q, spinup_fail_cond, rd_spin);
        drive_d = rc_next(drive_q, drive_fail_cond, rd_drive);
    end

    // per-fan flags update whatever the alert enables say
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            stall_q <= FLAGS_RESET[NUM_FANS-1:0];
            spin_q <= FLAGS_RESET[NUM_FANS-1:0];
            drive_q <= FLAGS_RESET[NUM_FANS-1:0];
        end else begin
            stall_q <= stall_d;
            spin_q <= spin_d;
            drive_q <= drive_d;
        end
    end

    // watchdog runs always in continuous mode, else until first expiry
    assign watchdog_run = watchdog_continuous | ~wd_spent_q;

    // once-after-power-up latch
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wd_spent_q <= 1'b0;
        end else if (watchdog_expire && watchdog_run) begin
            wd_spent_q <= 1'b1;
        end
    end

    // expired flag: a new expiry beats a clearing read
    always_comb begin
        watch_d = watch_q;
        if (watchdog_expire && watchdog_run) begin
            watch_d = 1'b1;
        end else if (rd_summary) begin
            watch_d = 1'b0;
        end
    end

    // watchdog expired flag register
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            watch_q <= 1'b0;
        end else begin
            watch_q <= watch_d;
        end
    end

    // full duty force; expiry wins over a reprogram in the same cycle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            force_q <= FAN_ZERO;
        end else if (watchdog_expire && watchdog_run) begin
            force_q <= ~FAN_ZERO;
        end else begin
            force_q <= force_q & ~fan_reprogram;
        end
    end

    assign force_full_duty = force_q;

    // summary bits follow the per-fan registers directly
    assign any_drive_fail = |drive_q;
    assign any_spinup_fail = |spin_q;
    assign any_stall = |stall_q;

    // summary byte, unused bits zero
    always_comb begin
        summary = 8'h00;
        summary[SUM_WATCHDOG_BIT] = watch_q;
        summary[SUM_DRIVE_FAIL_BIT] = any_drive_fail;
        summary[SUM_SPINUP_BIT] = any_spinup_fail;
        summary[SUM_STALL_BIT] = any_stall;
    end

    // read mux; flags are sampled before the clearing edge
    always_comb begin
        rdata_d = UNMAPPED_READ_VALUE;
        if (reg_addr == ADDR_GLOBAL_CONFIGURATION) begin
            rdata_d = cfg_q & CFG_WRITE_MASK;
        end else if (reg_addr == ADDR_FAULT_SUMMARY) begin
            rdata_d = summary;
        end else if (reg_addr == ADDR_STALL_STATUS) begin
            rdata_d = to_byte(stall_q);
        end else if (reg_addr == ADDR_SPINUP_STATUS) begin
            rdata_d = to_byte(spin_q);
        end else if (reg_addr == ADDR_DRIVE_FAIL_STATUS) begin
            rdata_d = to_byte(drive_q);
        end else if (reg_addr == ADDR_ALERT_ENABLE) begin
            rdata_d = to_byte(alert_en_q);
        end else begin
            rdata_d = UNMAPPED_READ_VALUE;
        end
    end

    // read data register, held until the next read
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= READ_DATA_RESET;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd;
            if (reg_rd) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;

    // alert request: enabled fan errors plus the watchdog flag
    always_comb begin
        alert_req = |(alert_en_q & (stall_q | spin_q | drive_q));
        alert_req = alert_req | watch_q;
        if (alert_mask) begin
            alert_req = 1'b0;
        end
    end

    // alert pin register; rises one mclk cycle after the request goes away
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            alert_n_q <= 1'b1;
        end else begin
            alert_n_q <= ~alert_req;
        end
    end

    assign alert_n = alert_n_q;

    // internal oscillator divider; stands in for the on-chip oscillator
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            div_q <= DIV_ZERO;
        end else if (div_q == DIV_LAST) begin
            div_q <= DIV_ZERO;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    assign int_tick = (div_q == DIV_LAST);

    // internal tachometer clock square wave for the pin
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            int_clk_q <= 1'b0;
        end else if (int_tick) begin
            int_clk_q <= ~int_clk_q;
        end
    end

    // push-pull drive of the pin only while the drive bit is set
    assign tach_pin_oe = tach_clock_drive_out;
    assign tach_pin_out = tach_clock_drive_out & int_clk_q;

    // link side: one toggle per rising pin clock edge, nothing else there
    always_ff @(posedge tach_pin_clk or negedge rst_b) begin
        if (!rst_b) begin
            link_tgl_q <= 1'b0;
        end else begin
            link_tgl_q <= ~link_tgl_q;
        end
    end

    // toggle crossing; the pin clock must stay below half of mclk
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            link_sync1_q <= 1'b0;
            link_sync2_q <= 1'b0;
            link_sync3_q <= 1'b0;
        end else begin
            link_sync1_q <= link_tgl_q;
            link_sync2_q <= link_sync1_q;
            link_sync3_q <= link_sync2_q;
        end
    end

    // edge detect reads only the settled stages
    assign ext_tick = link_sync2_q ^ link_sync3_q;

    // driving out forces the internal source whatever the use bit says
    assign use_ext_clock = external_tach_clock_use & ~tach_clock_drive_out;

    // time base handed to the tachometer measurement logic
    assign tach_tick = use_ext_clock ? ext_tick : int_tick;

endmodule

// *** tb/fan_alert_monitor.sv ***
/*
 * checker for the fan fault status and alert block.
 * assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
module fan_alert_monitor
    import fan_alert_pkg::*;
#(
    parameter int NUM_FANS = FAN_COUNT
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic sw_lock,
    input wire logic [NUM_FANS-1:0] stall_cond,
    input wire logic watchdog_expire,
    input wire logic [NUM_FANS-1:0] fan_reprogram,
    input wire logic watchdog_run,
    input wire logic [NUM_FANS-1:0] force_full_duty,
    input wire logic bus_timeout_enable,
    input wire logic alert_n,
    input wire logic tach_pin_out,
    input wire logic tach_pin_oe
);
    logic [7:0] cfg_q; // shadow of the configuration
    logic [NUM_FANS-1:0] en_q; // shadow of the alert enables

    // config shadow; locked writes dropped, as the device must
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q <= 8'h00;
        end else if (reg_wr && reg_addr == ADDR_GLOBAL_CONFIGURATION && !sw_lock) begin
            cfg_q <= reg_wdata & CFG_WRITE_MASK;
        end
    end

    // enable shadow; this register has no lock
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            en_q <= '0;
        end else if (reg_wr && reg_addr == ADDR_ALERT_ENABLE) begin
            en_q <= reg_wdata[NUM_FANS-1:0];
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_mask_holds_alert: assert property (cfg_q[7] |=> alert_n)
        else $error("alert asserted while masked");
    a_enabled_stall_alerts: assert property (
        !cfg_q[7] && |(stall_cond & en_q) ##1 !cfg_q[7] |=> !alert_n)
        else $error("enabled stall gave no alert");
    a_timeout_follows_cfg: assert property (
        bus_timeout_enable == !cfg_q[CFG_TIMEOUT_DISABLE_BIT])
        else $error("bus timeout enable wrong");
    a_pin_oe_follows: assert property (tach_pin_oe == cfg_q[1])
        else $error("clock pin enable wrong");
    a_pin_quiet_input: assert property (!tach_pin_oe |-> !tach_pin_out)
        else $error("clock pin driven while input");
    a_cfg_reads_back: assert property (
        reg_rvalid && $past(reg_addr) == ADDR_GLOBAL_CONFIGURATION
        |-> reg_rdata == $past(cfg_q))
        else $error("config read back wrong");
    a_expiry_forces: assert property (
        watchdog_expire && watchdog_run |=> force_full_duty == '1)
        else $error("expiry did not force full duty");
    a_oneshot_spent: assert property (
        watchdog_expire && watchdog_run |=> watchdog_run == cfg_q[5])
        else $error("watchdog run after expiry wrong");
    a_force_holds: assert property (
        force_full_duty[0] && !fan_reprogram[0] |=> force_full_duty[0])
        else $error("force dropped without reprogram");
endmodule

// *** tb/fan_host_model.sv ***
/*
 * register host on the far side: one strobe per byte access.
 * assumes mclk is the block's clock; changes follow a rising edge.
 */
`timescale 1ns/1ps
module fan_host_model (
    input wire logic mclk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    // idle bus state at time zero
    initial begin
        reg_addr = 8'hff;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end

    // one write strobe; data turns over after, no stale value left
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge mclk) #1;
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask

    // read strobe, answer taken one cycle later with its valid
    task automatic rd(input logic [7:0] a, output logic [8:0] r);
        @(posedge mclk) #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge mclk) #1;
        reg_rd = 1'b0;
        r = {reg_rvalid, reg_rdata};
    endtask
endmodule

// *** tb/testbench.sv ***
/*
 * self-checking bench for the fan fault status and alert block.
 * assumes the host model drives the register port; pin clock gated.
 */
`timescale 1ns/1ps
module testbench;
    import fan_alert_pkg::*;
    localparam int TDIV = 4; // short internal time base
    // reset starts high so that its fall is an event the async resets see
    logic mclk = 0, rst_b = 1, sw_lock = 0, watchdog_expire = 0;
    logic pin_last = 0; // previous sampled level of the driven pin
    logic tach_clk = 0, tach_en = 0; // pin clock, runs in bursts only
    logic [4:0] stall_cond = 0, spinup_fail_cond = 0, drive_fail_cond = 0;
    logic [4:0] fan_reprogram = 0, force_full_duty;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, reg_rvalid, watchdog_run, bus_timeout_enable;
    logic alert_n, tach_pin_out, tach_pin_oe, tach_tick;
    int error_cnt = 0, checks = 0, cyc = 0, ticks = 0, rises = 0;
    // pin level: the device output wins while it drives
    wire tach_pin_clk = tach_pin_oe ? tach_pin_out : tach_clk;

    always #50 mclk = ~mclk;
    always #24 if (tach_en) tach_clk = ~tach_clk;

    // hang guard and tick counter
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        ticks <= ticks + int'(tach_tick);
        rises <= rises + int'(tach_pin_out & ~pin_last);
        pin_last <= tach_pin_out;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end

    fan_host_model host_inst (.mclk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata, .reg_rvalid);
    fan_fault_status_alert #(.INT_TACH_DIV(TDIV)) fan_fault_status_alert_inst (
        .mclk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .reg_rvalid, .sw_lock, .stall_cond, .spinup_fail_cond, .drive_fail_cond,
        .watchdog_expire, .fan_reprogram, .watchdog_run, .force_full_duty,
        .bus_timeout_enable, .alert_n, .tach_pin_clk, .tach_pin_out, .tach_pin_oe,
        .tach_tick);

    task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        logic [8:0] r;
        host_inst.rd(a, r);
        cmp(r, {1'b1, e});
    endtask

    task automatic step();
        @(posedge mclk) #1;
    endtask

    task automatic set_cond(input int k, input logic [4:0] v);
        case (k)
            0: stall_cond = v;
            1: spinup_fail_cond = v;
            default: drive_fail_cond = v;
        endcase
    endtask

    task automatic t_reset();
        cmp(9'({alert_n, bus_timeout_enable, watchdog_run, tach_pin_oe, force_full_duty}),
            9'h1c0);
        for (int a = 0; a < 10; a++) chk(8'(8'h20 + a), 8'h00);
    endtask

    task automatic t_config();
        host_inst.wr(ADDR_GLOBAL_CONFIGURATION, 8'hff);
        chk(ADDR_GLOBAL_CONFIGURATION, 8'he3);
        cmp(9'({bus_timeout_enable, tach_pin_oe}), 9'h001);
        sw_lock = 1;
        host_inst.wr(ADDR_GLOBAL_CONFIGURATION, 8'h00);
        chk(ADDR_GLOBAL_CONFIGURATION, 8'he3);
        sw_lock = 0;
        host_inst.wr(ADDR_GLOBAL_CONFIGURATION, 8'h40);
        cmp(9'({bus_timeout_enable, tach_pin_oe}), 9'h000);
        host_inst.wr(ADDR_GLOBAL_CONFIGURATION, 8'h00);
        chk(8'h30, 8'h00); // unmapped place
    endtask

    task automatic t_status();
        for (int k = 0; k < 3; k++) begin
            set_cond(k, 5'h11); // fans one and five
            step();
            set_cond(k, 5'h00);
            chk(ADDR_FAULT_SUMMARY, 8'h01 << k);
            chk(8'(ADDR_STALL_STATUS + k), 8'h11);
            chk(8'(ADDR_STALL_STATUS + k), 8'h00);
            set_cond(k, 5'h02); // fault that persists over reads
            chk(8'(ADDR_STALL_STATUS + k), 8'h02);
            chk(8'(ADDR_STALL_STATUS + k), 8'h02);
            set_cond(k, 5'h00);
            chk(8'(ADDR_STALL_STATUS + k), 8'h02);
            chk(ADDR_FAULT_SUMMARY, 8'h00);
            cmp(9'(alert_n), 9'h001);
        end
    endtask

    task automatic t_alert();
        host_inst.wr(ADDR_ALERT_ENABLE, 8'h10);
        stall_cond = 5'h01; // fan one is not enabled
        step();
        stall_cond = 5'h10;
        step();
        stall_cond = 5'h00;
        cmp(9'(alert_n), 9'h001);
        step();
        cmp(9'(alert_n), 9'h000);
        host_inst.wr(ADDR_GLOBAL_CONFIGURATION, 8'h80);
        step();
        cmp(9'(alert_n), 9'h001);
        host_inst.wr(ADDR_GLOBAL_CONFIGURATION, 8'h00);
        step();
        cmp(9'(alert_n), 9'h000);
        chk(ADDR_STALL_STATUS, 8'h11);
        step();
        cmp(9'(alert_n), 9'h001);
        host_inst.wr(ADDR_ALERT_ENABLE, 8'h00);
    endtask

    task automatic expire();
        watchdog_expire = 1;
        step();
        watchdog_expire = 0;
    endtask

    task automatic t_watchdog();
        expire();
        cmp(9'({watchdog_run, force_full_duty}), 9'h01f);
        chk(ADDR_FAULT_SUMMARY, 8'h80);
        chk(ADDR_FAULT_SUMMARY, 8'h00);
        fan_reprogram = 5'h04;
        step();
        fan_reprogram = 5'h00;
        cmp(9'(force_full_duty), 9'h01b);
        expire();
        cmp(9'(force_full_duty), 9'h01b);
        chk(ADDR_FAULT_SUMMARY, 8'h00);
        host_inst.wr(ADDR_GLOBAL_CONFIGURATION, 8'h20);
        cmp(9'(watchdog_run), 9'h001);
        expire();
        cmp(9'({watchdog_run, force_full_duty}), 9'h03f);
        chk(ADDR_FAULT_SUMMARY, 8'h80);
    endtask

    // one rising edge of the pin clock, then the pin clock stands low
    task automatic pin_edge();
        tach_en = 1;
        @(negedge tach_clk);
        tach_en = 0;
    endtask

    task automatic t_tach(input logic [7:0] c, input int want);
        int t0;
        int r0;
        host_inst.wr(ADDR_GLOBAL_CONFIGURATION, c);
        repeat (4) step();
        t0 = ticks;
        r0 = rises;
        for (int i = 0; i < 4; i++) begin
            if (i < 3) pin_edge();
            repeat (10) @(posedge mclk);
        end
        #1 cmp(9'(ticks - t0), 9'(want));
        cmp(9'(rises - r0), 9'(c[1] ? 40 / (2 * TDIV) : 0));
    endtask

    task automatic finish_test();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #1 rst_b = 0;
        repeat (4) @(posedge mclk);
        #1 rst_b = 1;
        t_reset();
        t_config();
        t_status();
        t_alert();
        t_watchdog();
        t_tach(8'h01, 3);
        t_tach(8'h00, 40 / TDIV);
        t_tach(8'h03, 40 / TDIV);
        finish_test();
    end
endmodule

bind fan_fault_status_alert fan_alert_monitor #(.NUM_FANS(NUM_FANS)) fan_alert_monitor_inst (
    .mclk, .rst_b, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .reg_rvalid, .sw_lock,
    .stall_cond, .watchdog_expire, .fan_reprogram, .watchdog_run, .force_full_duty,
    .bus_timeout_enable, .alert_n, .tach_pin_out, .tach_pin_oe);
